// ### inc/ssc_pkg.sv
// Constants and types of the serial channel core
// How it works
// - UART bit: 16 counts, vote 7/8/9
// - Start bit needs two of three low
// - Clock-out sync receive samples on chosen edge
// - Clock-in sync receive samples on chosen edge
// - Word moves to holding buffer, receive interrupt
// - Unread holding buffer: overrun, new word dropped
// - Ninth bit holds parity or data MSB
// - Wake-up filter: interrupt only when ninth set
// - Transmit tick every 16 base pulses
// - Clock-out sync transmit shifts per chosen edge
// - Clock-in sync transmit shifts per peer edge
// - UART transmit starts on next bit tick
// - Flow control: start on tick after permit
// - Permit high holds next frame, not current
// - Held sender still interrupts and accepts data
// - Parity only 7/8-bit UART, sense chooses even
// - Transmit write inserts parity bit automatically
// - Receive parity compared after transfer, flag error
// - Stop bit majority low sets framing flag
// - Receive interrupt timing depends on format
// - Transmit interrupt as stop bit starts
// - Reading status clears all error flags

package ssc_pkg;

   // ********************************
   // Register map (byte addresses)
   // ********************************
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_DATA = 8'h08;
   localparam logic [7:0] A_BAUD = 8'h0c;

   // Control fields
   localparam int C_MODE = 0;
   localparam int C_PE   = 2;
   localparam int C_EVEN = 3;
   localparam int C_WU   = 4;
   localparam int C_FCE  = 5;
   localparam int C_DIR  = 6;
   localparam int C_EDGE = 7;
   localparam int C_RXE  = 8;

   // Status fields
   localparam int S_NINTH = 0;
   localparam int S_FRAME_FAULT_FLAG  = 1;
   localparam int S_PARITY_FAULT_FLAG  = 2;
   localparam int S_OVERRUN_FLAG  = 3;
   localparam int S_TXB   = 4;
   localparam int S_FULL  = 5;
   localparam int D_NINTH = 8;

   localparam logic [15:0] BAUD_RST = 16'h0001;
   localparam logic [1:0]  RESP_OK  = 2'h0;
   localparam logic [1:0]  RESP_ERR = 2'h2;

   // ********************************
   // Timing counts
   // ********************************
   localparam logic [3:0] SMP_A     = 4'h7;
   localparam logic [3:0] SMP_B     = 4'h8;
   localparam logic [3:0] SMP_C     = 4'h9;
   localparam logic [3:0] CNT_LAST  = 4'hf;
   localparam logic [3:0] SYNC_BITS = 4'h8;
   localparam logic [3:0] FULL_BITS = 4'h9;

   typedef enum logic [1:0] {SSC_SYNC, SSC_U7, SSC_U8, SSC_U9} ssc_mode_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ssc_rx_e;

endpackage

// ### hw/ssc_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module ssc_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Data
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_ff <= '1;
         q       <= '1;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end

endmodule // ssc_sync2

`default_nettype wire

// ### hw/ssc_core.sv
// Serial channel core: UART and synchronous shift modes, AXI4-Lite registers
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module ssc_core
   import ssc_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output var  logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output var  logic        wready,
   output var  logic [1:0]  bresp,
   output var  logic        bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output var  logic        arready,
   output var  logic [31:0] rdata,
   output var  logic [1:0]  rresp,
   output var  logic        rvalid,
   input  wire logic        rready,
   // Serial pins
   input  wire logic        serial_in_pin,
   output var  logic        serial_out_pin,
   input  wire logic        shift_clock_pin_i,
   output var  logic        shift_clock_pin_o,
   output var  logic        shift_clock_pin_oe,
   input  wire logic        send_permit_n,
   // Events
   output var  logic        rx_irq,
   output var  logic        tx_irq
);

   // ********************************
   // State
   // ********************************
   typedef struct packed {
      logic        aw_got;
      logic [7:0]  aw_a;
      logic        w_got;
      logic [31:0] w_d;
      logic [3:0]  w_s;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [8:0]  ctrl;
      logic [15:0] baud;
      logic [15:0] bcnt;
      logic [8:0]  txbuf;
      logic        pend;
      logic        tbusy;
      logic [10:0] tsh;
      logic [3:0]  tleft;
      logic [3:0]  tcnt;
      logic        txd;
      logic        sclk;
      logic        sck_oe;
      logic        pin_prev;
      ssc_rx_e     rst;
      logic [3:0]  rcnt;
      logic [1:0]  votes;
      logic [8:0]  rsh;
      logic [3:0]  rbits;
      logic [7:0]  hold;
      logic        ninth;
      logic        full;
      logic        frame_fault_flag;
      logic        parity_fault_flag;
      logic        overrun_flag;
      logic        rx_irq;
      logic        tx_irq;
   } ssc_core_s;

   ssc_core_s q_ff;
   ssc_core_s nxt_q;

   logic [2:0]  pins_s;
   logic        rxd;
   logic        pin_s;
   logic        permit_n;
   ssc_mode_e   md;
   logic        pe_on;
   logic [3:0]  nd;
   logic        bt;
   logic        tt;
   logic        ev;
   logic        rise;
   logic        fall;
   logic        maj;
   logic        xfer;
   logic [8:0]  shn;
   logic [8:0]  xw;
   logic [8:0]  pbits;
   logic        par;
   logic        run;
   logic [31:0] wm;

   // Pins come from outside the clock domain
   ssc_sync2 #(.W(3)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({send_permit_n, shift_clock_pin_i, serial_in_pin}),
      .q       (pins_s)
   );

   assign rxd      = pins_s[0];
   assign pin_s    = pins_s[1];
   assign permit_n = pins_s[2];

   // Byte-lane merge of a write into an old register value
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ********************************
   // Next state
   // ********************************
   always_comb begin
      nxt_q = q_ff;
      nxt_q.rx_irq = 1'b0;
      nxt_q.tx_irq = 1'b0;
      md    = ssc_mode_e'(q_ff.ctrl[C_MODE +: 2]);
      pe_on = q_ff.ctrl[C_PE] && (md == SSC_U7 || md == SSC_U8);
      case (md)
         SSC_U7:  nd = 4'h7 + {3'h0, pe_on};
         SSC_U8:  nd = 4'h8 + {3'h0, pe_on};
         SSC_U9:  nd = FULL_BITS;
         default: nd = SYNC_BITS;
      endcase
      xfer  = 1'b0;
      shn   = {rxd, q_ff.rsh[8:1]};
      xw    = '0;
      maj   = (q_ff.votes[0] & q_ff.votes[1]) | (q_ff.votes[0] & rxd) |
              (q_ff.votes[1] & rxd);
      wm    = '0;
      par   = 1'b0;

      // Base serial clock: one enable pulse every baud+1 cycles
      bt = (q_ff.bcnt >= q_ff.baud);
      nxt_q.bcnt = bt ? '0 : q_ff.bcnt + 16'h0001;

      // Transmit bit tick every 16 base pulses
      tt = 1'b0;
      if (bt && md != SSC_SYNC) begin
         nxt_q.tcnt = q_ff.tcnt + 4'h1;
         tt = (q_ff.tcnt == CNT_LAST);
      end

      // Own shift clock idles high and only stops when high
      run = (md == SSC_SYNC) && !q_ff.ctrl[C_DIR] &&
            (q_ff.tbusy || q_ff.pend || (q_ff.ctrl[C_RXE] && !q_ff.full));
      nxt_q.sck_oe = (md == SSC_SYNC) && !q_ff.ctrl[C_DIR];
      if (q_ff.ctrl[C_DIR]) begin
         rise = pin_s && !q_ff.pin_prev;
         fall = !pin_s && q_ff.pin_prev;
      end else begin
         rise = bt && (run || !q_ff.sclk) && !q_ff.sclk;
         fall = bt && run && q_ff.sclk;
      end
      if (bt && (run || !q_ff.sclk)) begin
         nxt_q.sclk = !q_ff.sclk;
      end
      nxt_q.pin_prev = pin_s;
      ev = (md == SSC_SYNC) && (q_ff.ctrl[C_EDGE] ? rise : fall);

      // ********************************
      // Status read clears (set below wins)
      // ********************************
      if (arvalid && q_ff.arready) begin
         nxt_q.rvalid = 1'b1;
         nxt_q.rresp  = RESP_OK;
         nxt_q.rdata  = '0;
         case (araddr)
            A_CTRL: nxt_q.rdata[8:0] = q_ff.ctrl;
            A_STAT: begin
               nxt_q.rdata[S_NINTH] = q_ff.ninth;
               nxt_q.rdata[S_FRAME_FAULT_FLAG]  = q_ff.frame_fault_flag;
               nxt_q.rdata[S_PARITY_FAULT_FLAG]  = q_ff.parity_fault_flag;
               nxt_q.rdata[S_OVERRUN_FLAG]  = q_ff.overrun_flag;
               nxt_q.rdata[S_TXB]   = q_ff.tbusy | q_ff.pend;
               nxt_q.rdata[S_FULL]  = q_ff.full;
               nxt_q.frame_fault_flag = 1'b0;
               nxt_q.parity_fault_flag = 1'b0;
               nxt_q.overrun_flag = 1'b0;
            end
            A_DATA: begin
               nxt_q.rdata[7:0] = q_ff.hold;
               nxt_q.full = 1'b0;
            end
            A_BAUD: nxt_q.rdata[15:0] = q_ff.baud;
            default: nxt_q.rresp = RESP_ERR;
         endcase
      end
      if (q_ff.rvalid && rready) begin
         nxt_q.rvalid = 1'b0;
      end

      // ********************************
      // UART receiver
      // ********************************
      if (md != SSC_SYNC && bt) begin
         if (q_ff.rst == RX_IDLE) begin
            nxt_q.rcnt = '0;
            // Idle line leaves no stale bit count for sync mode
            nxt_q.rbits = '0;
            if (q_ff.ctrl[C_RXE] && !rxd) begin
               nxt_q.rst = RX_START;
            end
         end else begin
            nxt_q.rcnt = q_ff.rcnt + 4'h1;
            if (q_ff.rcnt == SMP_A) begin
               nxt_q.votes[0] = rxd;
            end
            if (q_ff.rcnt == SMP_B) begin
               nxt_q.votes[1] = rxd;
            end
            if (q_ff.rcnt == SMP_C) begin
               case (q_ff.rst)
                  RX_START: begin
                     nxt_q.rst   = maj ? RX_IDLE : RX_DATA;
                     nxt_q.rbits = '0;
                  end
                  RX_DATA: begin
                     shn = {maj, q_ff.rsh[8:1]};
                     nxt_q.rsh   = shn;
                     nxt_q.rbits = q_ff.rbits + 4'h1;
                     if (q_ff.rbits == nd - 4'h1) begin
                        nxt_q.rst = RX_STOP;
                        xfer = (nd == FULL_BITS);
                     end
                  end
                  RX_STOP: begin
                     nxt_q.rst = RX_IDLE;
                     if (!maj) begin
                        nxt_q.frame_fault_flag = 1'b1;
                     end
                     shn  = q_ff.rsh;
                     xfer = (nd != FULL_BITS);
                  end
                  default: nxt_q.rst = RX_IDLE;
               endcase
            end
         end
      end

      // ********************************
      // Synchronous receiver
      // ********************************
      if (md == SSC_SYNC) begin
         nxt_q.rst = RX_IDLE;
         if (ev && q_ff.ctrl[C_RXE]) begin
            nxt_q.rsh   = shn;
            nxt_q.rbits = q_ff.rbits + 4'h1;
            if (q_ff.rbits == SYNC_BITS - 4'h1) begin
               nxt_q.rbits = '0;
               xfer = 1'b1;
            end
         end
      end

      // Word transfer to the holding buffer
      xw    = shn >> (FULL_BITS - nd);
      pbits = (md == SSC_U8) ? xw : {1'b0, xw[7:0]};
      if (xfer) begin
         if (q_ff.full) begin
            nxt_q.overrun_flag = 1'b1;
         end else begin
            nxt_q.full = 1'b1;
            nxt_q.hold = (md == SSC_U7 && !pe_on) ? {1'b0, xw[6:0]} : xw[7:0];
            if (md == SSC_U9 || (md == SSC_U8 && pe_on)) begin
               nxt_q.ninth = xw[8];
            end
            if (pe_on && ((^pbits) ^ !q_ff.ctrl[C_EVEN])) begin
               nxt_q.parity_fault_flag = 1'b1;
            end
            // Slaves on a shared bus are only interrupted by address words
            nxt_q.rx_irq = !(md == SSC_U9 && q_ff.ctrl[C_WU] && !xw[8]);
         end
      end

      // ********************************
      // Transmitter
      // ********************************
      if (md != SSC_SYNC) begin
         if (tt) begin
            if (q_ff.tbusy && q_ff.tleft == '0) begin
               nxt_q.tbusy = 1'b0;
            end
            // Permit is only looked at between frames
            if ((!q_ff.tbusy || q_ff.tleft == '0) && q_ff.pend &&
                !(q_ff.ctrl[C_FCE] && permit_n)) begin
               nxt_q.pend  = 1'b0;
               nxt_q.tbusy = 1'b1;
               nxt_q.tsh   = {1'b1, q_ff.txbuf | ~(9'h1ff >> (FULL_BITS - nd)),
                              1'b0};
               nxt_q.tleft = nd + 4'h2;
            end
            if (nxt_q.tbusy && nxt_q.tleft != '0) begin
               nxt_q.txd   = nxt_q.tsh[0];
               nxt_q.tsh   = {1'b1, nxt_q.tsh[10:1]};
               nxt_q.tleft = nxt_q.tleft - 4'h1;
               if (nxt_q.tleft == '0) begin
                  nxt_q.tx_irq = 1'b1;
               end
            end
         end
      end else begin
         if (q_ff.pend && !q_ff.tbusy) begin
            nxt_q.pend  = 1'b0;
            nxt_q.tbusy = 1'b1;
            nxt_q.tsh   = {2'b11, q_ff.txbuf};
            nxt_q.txd   = q_ff.txbuf[0];
            nxt_q.tleft = SYNC_BITS;
         end else if (ev && q_ff.tbusy) begin
            nxt_q.tsh   = {1'b1, q_ff.tsh[10:1]};
            nxt_q.tleft = q_ff.tleft - 4'h1;
            nxt_q.txd   = q_ff.tsh[1];
            if (q_ff.tleft == 4'h1) begin
               nxt_q.tbusy  = 1'b0;
               nxt_q.txd    = 1'b1;
               nxt_q.tx_irq = 1'b1;
            end
         end
      end

      // ********************************
      // Register writes
      // ********************************
      if (awvalid && q_ff.awready) begin
         nxt_q.aw_got = 1'b1;
         nxt_q.aw_a   = awaddr;
      end
      if (wvalid && q_ff.wready) begin
         nxt_q.w_got = 1'b1;
         nxt_q.w_d   = wdata;
         nxt_q.w_s   = wstrb;
      end
      if (q_ff.aw_got && q_ff.w_got && !q_ff.bvalid) begin
         nxt_q.aw_got = 1'b0;
         nxt_q.w_got  = 1'b0;
         nxt_q.bvalid = 1'b1;
         nxt_q.bresp  = RESP_OK;
         case (q_ff.aw_a)
            A_CTRL: begin
               wm = merge({23'h0, q_ff.ctrl}, q_ff.w_d, q_ff.w_s);
               nxt_q.ctrl = wm[8:0];
            end
            A_DATA: begin
               wm  = merge({23'h0, q_ff.txbuf}, q_ff.w_d, q_ff.w_s);
               par = q_ff.ctrl[C_EVEN] ? 1'b0 : 1'b1;
               // Parity replaces bit 7 or the ninth bit at write time
               if (pe_on && md == SSC_U7) begin
                  wm[7] = (^wm[6:0]) ^ par;
               end
               if (pe_on && md == SSC_U8) begin
                  wm[D_NINTH] = (^wm[7:0]) ^ par;
               end
               nxt_q.txbuf = wm[8:0];
               nxt_q.pend  = 1'b1;
            end
            A_BAUD: begin
               wm = merge({16'h0, q_ff.baud}, q_ff.w_d, q_ff.w_s);
               nxt_q.baud = wm[15:0];
            end
            A_STAT: nxt_q.bresp = RESP_OK;
            default: nxt_q.bresp = RESP_ERR;
         endcase
      end
      if (q_ff.bvalid && bready) begin
         nxt_q.bvalid = 1'b0;
      end
      nxt_q.awready = !nxt_q.aw_got && !nxt_q.bvalid;
      nxt_q.wready  = !nxt_q.w_got && !nxt_q.bvalid;
      nxt_q.arready = !nxt_q.rvalid;

      if (!aresetn) begin
         nxt_q      = '0;
         nxt_q.txd  = 1'b1;
         nxt_q.sclk = 1'b1;
         nxt_q.pin_prev = 1'b1;
         nxt_q.baud = BAUD_RST;
      end
   end

   always_ff @(posedge aclk) begin
      q_ff <= nxt_q;
   end

   // ********************************
   // Outputs
   // ********************************
   assign awready            = q_ff.awready;
   assign wready             = q_ff.wready;
   assign bvalid             = q_ff.bvalid;
   assign bresp              = q_ff.bresp;
   assign arready            = q_ff.arready;
   assign rvalid             = q_ff.rvalid;
   assign rresp              = q_ff.rresp;
   assign rdata              = q_ff.rdata;
   assign serial_out_pin     = q_ff.txd;
   assign shift_clock_pin_o  = q_ff.sclk;
   assign shift_clock_pin_oe = q_ff.sck_oe;
   assign rx_irq             = q_ff.rx_irq;
   assign tx_irq             = q_ff.tx_irq;

endmodule // ssc_core

`default_nettype wire

// ### sim/ssc_core_props.sv
// Port-level timing checks for the serial channel core
`timescale 1ns/1ns
`default_nettype none

module ssc_chk (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   // Serial pins and events
   input wire logic        serial_out_pin,
   input wire logic        shift_clock_pin_o,
   input wire logic        shift_clock_pin_oe,
   input wire logic        rx_irq,
   input wire logic        tx_irq
);
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_write_answer: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
      else $error("write response not two cycles after take");
   a_bresp_once: assert property (bvalid && bready |=> !bvalid)
      else $error("write response not retired after accept");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data not one cycle after take");
   a_rdata_once: assert property (rvalid && rready |=> !rvalid)
      else $error("read data not retired after accept");
   a_rx_irq_pulse: assert property (rx_irq |=> !rx_irq)
      else $error("receive event longer than one cycle");
   a_tx_irq_pulse: assert property (tx_irq |=> !tx_irq)
      else $error("transmit event longer than one cycle");
   a_tx_irq_stop: assert property (tx_irq |-> ##[0:2] serial_out_pin)
      else $error("transmit event not at stop level");
   a_clk_out_rate: assert property (shift_clock_pin_oe && $changed(shift_clock_pin_o)
      |=> $stable(shift_clock_pin_o))
      else $error("emitted shift clock faster than base pulse");
   a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> serial_out_pin && !tx_irq)
      else $error("serial output not idle after reset");
endmodule // ssc_chk

`default_nettype wire

// ### sim/ssc_peer.sv
// Far-side model: UART peer and external shift register
`timescale 1ns/1ns
`default_nettype none

module ssc_peer (
   // Lines into the core
   output var  logic rxd,
   output var  logic sclk,
   output var  logic permit_n,
   // Line from the core
   input  wire logic txd
);
   // ****************************************
   // Line timing: 16 base pulses of 8 ns
   // ****************************************
   localparam int BIT_NS  = 128;
   localparam int HALF_NS = 16;

   initial begin
      rxd = 1'b1;
      sclk = 1'b1;
      permit_n = 1'b0;
   end

   task hold(input logic v);
      #1;
      permit_n = v;
   endtask

   task send(input logic [9:0] b, input int n, input logic stop);
      // Step off the clock edge
      #1;
      rxd = 1'b0;
      #BIT_NS;
      for (int i = 0; i < n; i++) begin
         rxd = b[i];
         #BIT_NS;
      end
      rxd = stop;
      #BIT_NS;
      rxd = 1'b1; // Pulled up between frames
   endtask

   task grab(output logic [9:0] b, input int n);
      b = '0;
      @(negedge txd);
      #(BIT_NS / 2);
      for (int i = 0; i < n; i++) begin
         #BIT_NS;
         b[i] = txd;
      end
   endtask

   // Clock idles high; data moves on the falling edge, core samples on the rising
   task shift(input logic [7:0] din, output logic [7:0] dout);
      #1;
      for (int i = 0; i < 8; i++) begin
         #HALF_NS;
         sclk = 1'b0;
         rxd = din[i];
         #HALF_NS;
         dout[i] = txd;
         sclk = 1'b1;
      end
      #HALF_NS;
      rxd = 1'b1;
   endtask
endmodule // ssc_peer

`default_nettype wire

// ### sim/test_serial_channel_rx_tx_core.sv
// Self-checking testbench of the serial channel core
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch %0t %s", $time, m); end end

module test_serial_channel_rx_tx_core;
   import ssc_pkg::*;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hf;
   logic        wvalid = 1'b0;
   logic [1:0]  bresp;
   logic        bvalid, awready, wready, arready, rvalid;
   logic        bready = 1'b0;
   logic [7:0]  araddr = 8'h00;
   logic        arvalid = 1'b0;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rready = 1'b0;
   logic        rxd, sclk, permit_n, txd, sck_o, sck_oe, rx_irq, tx_irq;
   int          n_fail = 0;
   int          n_compared = 0;
   int          n_rxi = 0;
   int          n_txi = 0;
   int          n_fall = 0;

   always #2 aclk = ~aclk;
   always @(posedge aclk) begin
      if (rx_irq === 1'b1) n_rxi++;
      if (tx_irq === 1'b1) n_txi++;
   end
   always @(negedge txd) n_fall++;

   ssc_core u_ssc_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .serial_in_pin(rxd), .serial_out_pin(txd), .shift_clock_pin_i(sclk),
      .shift_clock_pin_o(sck_o), .shift_clock_pin_oe(sck_oe), .send_permit_n(permit_n),
      .rx_irq(rx_irq), .tx_irq(tx_irq));
   ssc_peer u_ssc_peer (.rxd(rxd), .sclk(sclk), .permit_n(permit_n), .txd(txd));

   // ****************************************
   // Register bus master
   // ****************************************
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin do @(posedge aclk); while (!awready); awvalid <= 1'b0; end
         begin do @(posedge aclk); while (!wready); wvalid <= 1'b0; end
      join
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   logic [31:0] v;
   logic [1:0]  r;
   logic [9:0]  got;
   logic [7:0]  g8;
   int          k;

   task t_regs;
      rd(A_CTRL, v, r);
      `CHK(v, 32'h0, "ctrl reset")
      rd(A_BAUD, v, r);
      `CHK(v[15:0], BAUD_RST, "baud reset")
      wr(A_CTRL, 32'h1ab, r);
      rd(A_CTRL, v, r);
      `CHK(v[8:0], 9'h1ab, "ctrl readback")
      rd(8'h10, v, r);
      `CHK({r, v}, {RESP_ERR, 32'h0}, "unmapped read")
      wr(8'h14, 32'h1, r);
      `CHK(r, RESP_ERR, "unmapped write")
      wr(A_CTRL, 32'h0, r);
      $display("test regs done");
   endtask

   task tx_one(input ssc_mode_e m, input logic pe, input logic ev, input logic [8:0] d);
      logic [9:0] exp;
      int nd;
      nd = (m == SSC_U7) ? 7 : (m == SSC_U9) ? 9 : 8;
      exp = {1'b0, d} & ((10'h1 << nd) - 10'h1);
      if (pe) exp[nd] = ^exp ^ !ev;
      wr(A_CTRL, {28'h0, ev, pe, m}, r);
      k = n_txi;
      fork
         u_ssc_peer.grab(got, nd + int'(pe));
         wr(A_DATA, {23'h0, d}, r);
      join
      #256;
      `CHK(got, exp, "tx frame")
      `CHK(n_txi, k + 1, "tx event")
   endtask

   task t_tx;
      tx_one(SSC_U7, 1'b1, 1'b0, 9'h035);
      tx_one(SSC_U8, 1'b1, 1'b1, 9'h0a5);
      tx_one(SSC_U9, 1'b0, 1'b0, 9'h1a5);
      tx_one(SSC_U8, 1'b0, 1'b0, 9'h0c3);
      $display("test tx done");
   endtask

   task t_rx;
      wr(A_CTRL, 32'h10e, r);
      k = n_rxi;
      u_ssc_peer.send(10'h03c, 9, 1'b1);
      rd(A_DATA, v, r);
      `CHK(v[7:0], 8'h3c, "rx word")
      rd(A_STAT, v, r);
      `CHK(v[3:0], 4'h0, "clean status")
      u_ssc_peer.send(10'h15a, 9, 1'b0);
      rd(A_STAT, v, r);
      `CHK(v[5:0], 6'b100111, "parity and frame faults")
      // Low stop bit restarts the receiver; let that false start die out
      #256;
      u_ssc_peer.send(10'h011, 9, 1'b1);
      rd(A_STAT, v, r);
      `CHK(v[3:0], 4'b1001, "overrun")
      rd(A_STAT, v, r);
      `CHK(v[3:1], 3'b000, "flags cleared")
      rd(A_DATA, v, r);
      `CHK(v[7:0], 8'h5a, "holding kept")
      `CHK(n_rxi, k + 2, "rx events")
      $display("test rx done");
   endtask

   task t_cts;
      wr(A_CTRL, 32'h022, r);
      u_ssc_peer.hold(1'b1);
      k = n_fall;
      wr(A_DATA, 32'h81, r);
      #2000;
      `CHK(n_fall, k, "held by permit")
      rd(A_STAT, v, r);
      `CHK(v[S_TXB], 1'b1, "word kept while held")
      fork
         u_ssc_peer.grab(got, 8);
         begin #100 u_ssc_peer.hold(1'b0); end
      join
      `CHK(got[7:0], 8'h81, "sent after permit")
      #256;
      $display("test cts done");
   endtask

   task t_wake;
      wr(A_CTRL, 32'h113, r);
      k = n_rxi;
      u_ssc_peer.send(10'h07e, 9, 1'b1);
      `CHK(n_rxi, k, "filtered word")
      rd(A_DATA, v, r);
      u_ssc_peer.send(10'h181, 9, 1'b1);
      `CHK(n_rxi, k + 1, "address word")
      rd(A_DATA, v, r);
      `CHK(v[7:0], 8'h81, "nine bit word")
      $display("test wake done");
   endtask

   task t_sync;
      wr(A_CTRL, 32'h1c0, r);
      wr(A_DATA, 32'h96, r);
      k = n_txi;
      u_ssc_peer.shift(8'h4b, g8);
      #64;
      `CHK(g8, 8'h96, "sync tx taken clock")
      `CHK(n_txi, k + 1, "sync tx event")
      rd(A_DATA, v, r);
      `CHK(v[7:0], 8'h4b, "sync rx taken clock")
      wr(A_CTRL, 32'h180, r);
      wr(A_DATA, 32'h3a, r);
      repeat (200) @(posedge aclk);
      `CHK(n_txi, k + 2, "sync tx emitted clock")
      rd(A_DATA, v, r);
      `CHK(v[7:0], 8'hff, "sync rx emitted clock")
      $display("test sync done");
   endtask

   task give_verdict;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      t_regs;
      t_tx;
      t_rx;
      t_cts;
      t_wake;
      t_sync;
      give_verdict;
   end

   initial begin
      #300000;
      n_fail++;
      give_verdict;
   end
endmodule // test_serial_channel_rx_tx_core

bind ssc_core ssc_chk u_ssc_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
   .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
   .rready(rready), .serial_out_pin(serial_out_pin), .shift_clock_pin_o(shift_clock_pin_o),
   .shift_clock_pin_oe(shift_clock_pin_oe), .rx_irq(rx_irq), .tx_irq(tx_irq));

`default_nettype wire
